// ===== bench/sbtc_ext_clk_model.sv
// Behavioural model of the external clock source wired to the oscillator pins
module sbtc_ext_clk_model (
   input wire logic ref_clk,
   output logic lvl
);
   timeunit 1ns;
   timeprecision 1ps;

   // Clock stands low between bursts, so no stray edge reaches the counter
   initial begin
      lvl = 1'b0;
   end

   // One rising edge per loop; half sets how slowly the source runs
   task automatic burst(input int n, input int half);
      for (int i = 0; i < n; i++) begin
         repeat (half) @(posedge ref_clk);
         lvl <= 1'b1;
         repeat (half) @(posedge ref_clk);
         lvl <= 1'b0;
      end
   endtask : burst
endmodule : sbtc_ext_clk_model

// ===== bench/test_sbtc_top.sv
// Self-checking testbench of the sixteen-bit timer/counter
`include "sbtc_params.svh"

module test_sbtc_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk, arst_n, psel, penable, pwrite, cmp_unit0_trigger, cmp_unit1_trigger;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, er, irq, use_in, ext_lvl, in_pin, out_pin, osc_inverter_en;
   logic osc_in_pin_o, osc_in_pin_oe_n, osc_out_pin_o, osc_out_pin_oe_n;
   logic [31:0] seed = 32'h0000_0009;
   logic [15:0] got, v;
   logic [7:0] c;
   int num_errors = 0;
   int n_compared = 0;
   int mcnt;

   // --------------------------------------------------------------
   // Clock, pins and instances
   // --------------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   // Pin level: the device's drive wins, else the selected source
   assign in_pin = !osc_in_pin_oe_n ? osc_in_pin_o : (use_in & ext_lvl);
   assign out_pin = !osc_out_pin_oe_n ? osc_out_pin_o : (!use_in & ext_lvl);

   sbtc_ext_clk_model u_sbtc_ext_clk_model (.ref_clk(ref_clk), .lvl(ext_lvl));

   sbtc_top u_sbtc_top (
      .ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cmp_unit0_trigger(cmp_unit0_trigger),
      .cmp_unit1_trigger(cmp_unit1_trigger), .osc_in_pin_i(in_pin),
      .osc_in_pin_o(osc_in_pin_o), .osc_in_pin_oe_n(osc_in_pin_oe_n),
      .osc_out_pin_i(out_pin), .osc_out_pin_o(osc_out_pin_o),
      .osc_out_pin_oe_n(osc_out_pin_oe_n), .osc_inverter_en(osc_inverter_en), .irq(irq)
   );

   // --------------------------------------------------------------
   // Tasks
   // --------------------------------------------------------------
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   task automatic finish_test();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : finish_test

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
         num_errors++;
      end
   endtask : chk

   // One APB transfer; trg raises a trigger exactly in the access cycle
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic trg);
      int i;
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      cmp_unit0_trigger <= trg;
      i = 0;
      do begin
         @(posedge ref_clk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      cmp_unit0_trigger <= 1'b0;
      if (i >= 20) begin
         num_errors++;
         finish_test();
      end
   endtask : apb

   task automatic wrcnt(input logic [15:0] val);
      apb(1'b1, `SBTC_ADDR_CNT_LO, {24'h00_0000, val[7:0]}, 1'b0);
      apb(1'b1, `SBTC_ADDR_CNT_HI, {24'h00_0000, val[15:8]}, 1'b0);
   endtask : wrcnt

   task automatic rdcnt(output logic [15:0] val);
      apb(1'b0, `SBTC_ADDR_CNT_LO, 32'h0000_0000, 1'b0);
      val[7:0] = rd[7:0];
      apb(1'b0, `SBTC_ADDR_CNT_HI, 32'h0000_0000, 1'b0);
      val[15:8] = rd[7:0];
   endtask : rdcnt

   // --------------------------------------------------------------
   // Main sequence
   // --------------------------------------------------------------
   initial begin
      {psel, penable, pwrite, cmp_unit0_trigger, cmp_unit1_trigger, use_in} = '0;
      // Count has no reset, so a trigger held through reset gives it a known start
      cmp_unit1_trigger = 1'b1;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      arst_n = 1'b0;
      repeat (2) @(posedge ref_clk);
      arst_n <= 1'b1;
      cmp_unit1_trigger <= 1'b0;
      apb(1'b0, `SBTC_ADDR_CTRL, 32'h0000_0000, 1'b0);
      chk(rd, 32'h0000_0000);
      apb(1'b0, 8'h30, 32'h0000_0000, 1'b0);
      chk({31'h0, er}, 32'h0000_0001);
      // Timer mode: once per four clocks, sync bit makes no difference
      for (int s = 0; s < 2; s++) begin
         c = 8'(s << 2);
         apb(1'b1, `SBTC_ADDR_CTRL, {24'h0, c}, 1'b0);
         wrcnt(16'h0000);
         apb(1'b1, `SBTC_ADDR_CTRL, {24'h0, c | 8'h01}, 1'b0);
         repeat (40) @(posedge ref_clk);
         apb(1'b1, `SBTC_ADDR_CTRL, {24'h0, c}, 1'b0);
         rdcnt(got);
         chk(32'(got >= 10 && got <= 11), 32'h0000_0001);
      end
      // Counter mode over every source, sync and prescale setting
      for (int k = 0; k < 16; k++) begin
         c = 8'((k[1:0] << 4) | (k[3] << 3) | (k[2] << 2) | 2);
         apb(1'b1, `SBTC_ADDR_CTRL, {24'h0, c}, 1'b0);
         use_in <= k[3];
         repeat (4) @(posedge ref_clk);
         v = 16'(xs()) & 16'h7fff;
         wrcnt(v);
         rdcnt(got);
         chk({16'h0, got}, {16'h0, v});
         mcnt = v + (8 >> k[1:0]);
         apb(1'b1, `SBTC_ADDR_CTRL, {24'h0, c | 8'h01}, 1'b0);
         u_sbtc_ext_clk_model.burst(8, 2 + k % 3);
         repeat (8) @(posedge ref_clk);
         apb(1'b1, `SBTC_ADDR_CTRL, {24'h0, c}, 1'b0);
         rdcnt(got);
         chk({16'h0, got}, 32'(mcnt));
      end
      // Wrap and interrupt
      use_in <= 1'b0;
      apb(1'b1, `SBTC_ADDR_CTRL, 32'h0000_0002, 1'b0);
      apb(1'b1, `SBTC_ADDR_MASK, 32'h0000_0001, 1'b0);
      wrcnt(16'hfffc);
      apb(1'b1, `SBTC_ADDR_CTRL, 32'h0000_0003, 1'b0);
      u_sbtc_ext_clk_model.burst(8, 2);
      repeat (8) @(posedge ref_clk);
      apb(1'b1, `SBTC_ADDR_CTRL, 32'h0000_0002, 1'b0);
      rdcnt(got);
      chk({16'h0, got}, 32'h0000_0004);
      apb(1'b0, `SBTC_ADDR_STAT, 32'h0000_0000, 1'b0);
      chk(rd, 32'h0000_0001);
      for (int m = 0; m < 2; m++) begin
         apb(1'b1, `SBTC_ADDR_MASK, 32'(m), 1'b0);
         @(negedge ref_clk);
         chk({31'h0, irq}, 32'(m));
      end
      apb(1'b1, `SBTC_ADDR_STAT, 32'h0000_0001, 1'b0);
      @(negedge ref_clk);
      chk({31'h0, irq}, 32'h0000_0000);
      // Triggers clear the count, never set the flag, lose to a write
      wrcnt(16'h1234);
      @(posedge ref_clk);
      cmp_unit1_trigger <= 1'b1;
      @(posedge ref_clk);
      cmp_unit1_trigger <= 1'b0;
      rdcnt(got);
      chk({16'h0, got}, 32'h0000_0000);
      wrcnt(16'h5678);
      // Low-half write against a trigger: high half must survive too
      apb(1'b1, `SBTC_ADDR_CNT_LO, 32'h0000_0012, 1'b1);
      rdcnt(got);
      chk({16'h0, got}, 32'h0000_5612);
      apb(1'b1, `SBTC_ADDR_CNT_HI, 32'h0000_0000, 1'b0);
      apb(1'b1, `SBTC_ADDR_CTRL, 32'h0000_0000, 1'b1);
      rdcnt(got);
      chk({16'h0, got}, 32'h0000_0000);
      apb(1'b0, `SBTC_ADDR_STAT, 32'h0000_0000, 1'b0);
      chk(rd, 32'h0000_0000);
      // Oscillator enable takes the pins over
      apb(1'b1, `SBTC_ADDR_PDIR, 32'h0000_0000, 1'b0);
      apb(1'b1, `SBTC_ADDR_PDAT, 32'h0000_0003, 1'b0);
      apb(1'b0, `SBTC_ADDR_PDAT, 32'h0000_0000, 1'b0);
      chk(rd, 32'h0000_0003);
      chk({osc_in_pin_oe_n, osc_out_pin_oe_n, osc_inverter_en}, 32'h0000_0000);
      apb(1'b1, `SBTC_ADDR_CTRL, 32'h0000_0008, 1'b0);
      apb(1'b0, `SBTC_ADDR_PDAT, 32'h0000_0000, 1'b0);
      chk(rd, 32'h0000_0000);
      chk({osc_in_pin_oe_n, osc_out_pin_oe_n, osc_inverter_en}, 32'h0000_0007);
      // Count survives a reset taken while the counter is stopped
      wrcnt(16'hbeef);
      @(posedge ref_clk);
      arst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      arst_n <= 1'b1;
      rdcnt(got);
      chk({16'h0, got}, 32'h0000_beef);
      finish_test();
   end
endmodule : test_sbtc_top

// ===== hw/sbtc_params.svh
// Register map, field positions, reset values and timing counts of the timer block
`ifndef SBTC_PARAMS_SVH
`define SBTC_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte addresses (APB, one aligned word each)
// ----------------------------------------------------------------
`define SBTC_ADDR_CTRL 8'h10
`define SBTC_ADDR_CNT_LO 8'h14
`define SBTC_ADDR_CNT_HI 8'h18
`define SBTC_ADDR_STAT 8'h1C
`define SBTC_ADDR_MASK 8'h20
`define SBTC_ADDR_PDIR 8'h24
`define SBTC_ADDR_PDAT 8'h28

// ----------------------------------------------------------------
// Control register fields, and the overflow bit of status and mask
// ----------------------------------------------------------------
`define SBTC_BIT_RUN 0
`define SBTC_BIT_CS 1
`define SBTC_BIT_SYNC_N 2
`define SBTC_BIT_OSC_EN 3
`define SBTC_BIT_PS_LO 4
`define SBTC_BIT_PS_HI 5
`define SBTC_CTRL_W 6
`define SBTC_BIT_OVF 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SBTC_RST_CTRL 6'h00
`define SBTC_RST_PDIR 2'h3
`define SBTC_RST_PDAT 2'h0

// ----------------------------------------------------------------
// Timing: oscillator cycles per instruction cycle
// ----------------------------------------------------------------
`define SBTC_OSC_PER_INSTR 4
`define SBTC_INSTR_DIV_W 2

`endif

// ===== hw/sbtc_pkg.sv
// Shared types of the timer block
package sbtc_pkg;
   // Prescale ratio encodings of the two-bit select field
   typedef enum logic [1:0] {
      sbtc_ps_div1,
      sbtc_ps_div2,
      sbtc_ps_div4,
      sbtc_ps_div8
   } sbtc_prescale_type;

   typedef logic [7:0] sbtc_byte_type;
   typedef logic [15:0] sbtc_count_type;
endpackage : sbtc_pkg

// ===== hw/sbtc_prescaler.sv
// Input prescaler: divides rising edges of a level by 1, 2, 4 or 8
module sbtc_prescaler (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic src_level,
   input sbtc_pkg::sbtc_prescale_type sel,
   output logic div_level
);
   logic src_q;
   logic [2:0] cnt;
   logic next_src_q;
   logic [2:0] next_cnt;

   // Synchronous count of source rising edges
   always_comb begin
      next_src_q = src_level;
      next_cnt = cnt;
      if (src_level && !src_q) begin
         next_cnt = cnt + 3'h1;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         src_q <= 1'b0;
         cnt <= 3'h0;
      end else begin
         src_q <= next_src_q;
         cnt <= next_cnt;
      end
   end

   // Output level rises once per selected number of source edges
   always_comb begin
      case (sel)
         sbtc_pkg::sbtc_ps_div1: div_level = src_q;
         sbtc_pkg::sbtc_ps_div2: div_level = cnt[0];
         sbtc_pkg::sbtc_ps_div4: div_level = cnt[1];
         sbtc_pkg::sbtc_ps_div8: div_level = cnt[2];
         default: div_level = src_q;
      endcase
   end
endmodule : sbtc_prescaler

// ===== hw/sbtc_sync2.sv
// Two-flop synchroniser for a level
module sbtc_sync2 (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic d,
   output logic q
);
   logic meta;
   logic next_meta;
   logic next_q;

   // Stage one is read only by stage two
   always_comb begin
      next_meta = d;
      next_q = meta;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         meta <= 1'b0;
         q <= 1'b0;
      end else begin
         meta <= next_meta;
         q <= next_q;
      end
   end
endmodule : sbtc_sync2

// ===== hw/sbtc_top.sv
// Sixteen-bit timer/counter with APB registers, prescaler and overflow interrupt
//
// The APB interface to the registers was decided locally.
`include "sbtc_params.svh"

module sbtc_top (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic cmp_unit0_trigger,
   input wire logic cmp_unit1_trigger,
   input wire logic osc_in_pin_i,
   output logic osc_in_pin_o,
   output logic osc_in_pin_oe_n,
   input wire logic osc_out_pin_i,
   output logic osc_out_pin_o,
   output logic osc_out_pin_oe_n,
   output logic osc_inverter_en,
   output logic irq
);
   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [`SBTC_CTRL_W-1:0] ctrl;
   logic [`SBTC_CTRL_W-1:0] next_ctrl;
   sbtc_pkg::sbtc_count_type count;
   sbtc_pkg::sbtc_count_type next_count;
   logic overflow_flag;
   logic next_overflow_flag;
   logic overflow_irq_enable;
   logic next_overflow_irq_enable;
   logic [1:0] port_dir;
   logic [1:0] next_port_dir;
   logic [1:0] port_out;
   logic [1:0] next_port_out;
   logic [31:0] next_prdata;
   logic next_pready;
   logic next_pslverr;
   logic next_irq;
   logic next_in_oe_n;
   logic next_out_oe_n;
   logic next_inv_en;
   logic [`SBTC_INSTR_DIV_W-1:0] instr_div;
   logic [`SBTC_INSTR_DIV_W-1:0] next_instr_div;
   logic edge_q;
   logic next_edge_q;
   logic run_bit;
   logic clock_source_select;
   logic ext_sync_n;
   logic osc_enable;
   sbtc_pkg::sbtc_prescale_type ps_sel;
   logic src_level;
   logic div_level;
   logic div_synced;
   logic pick_level;
   logic inc;
   logic trig;
   logic acc;
   logic wr_lo;
   logic wr_hi;
   logic cnt_wr;
   logic ovf;
   logic mapped;

   // ----------------------------------------------------------------
   // Control field views
   // ----------------------------------------------------------------
   assign run_bit = ctrl[`SBTC_BIT_RUN];
   assign clock_source_select = ctrl[`SBTC_BIT_CS];
   assign ext_sync_n = ctrl[`SBTC_BIT_SYNC_N];
   assign osc_enable = ctrl[`SBTC_BIT_OSC_EN];
   assign ps_sel = sbtc_pkg::sbtc_prescale_type'(ctrl[`SBTC_BIT_PS_HI:`SBTC_BIT_PS_LO]);

   // ----------------------------------------------------------------
   // Clock source selection and prescaling
   // ----------------------------------------------------------------
   // Free-running instruction clock, one rising edge per four ref_clk
   always_comb begin
      next_instr_div = instr_div + `SBTC_INSTR_DIV_W'(1);
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         instr_div <= '0;
      end else begin
         instr_div <= next_instr_div;
      end
   end

   // Source level: instruction clock, or one of the two pins
   always_comb begin
      if (!clock_source_select) begin
         src_level = instr_div[`SBTC_INSTR_DIV_W-1];
      end else if (osc_enable) begin
         src_level = osc_in_pin_i;
      end else begin
         src_level = osc_out_pin_i;
      end
   end

   sbtc_prescaler u_prescaler (
      .clk(ref_clk),
      .arst_n(arst_n),
      .src_level(src_level),
      .sel(ps_sel),
      .div_level(div_level)
   );

   // Synchroniser sits after the prescaler, costing two cycles of latency
   sbtc_sync2 u_sync (
      .clk(ref_clk),
      .arst_n(arst_n),
      .d(div_level),
      .q(div_synced)
   );

   // Timer mode is always in step, so the sync bit is a don't-care there
   always_comb begin
      if (clock_source_select && !ext_sync_n) begin
         pick_level = div_synced;
      end else begin
         pick_level = div_level;
      end
   end

   // Rising edge of the picked level is one count step
   always_comb begin
      next_edge_q = pick_level;
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         edge_q <= 1'b0;
      end else begin
         edge_q <= next_edge_q;
      end
   end

   assign inc = pick_level && !edge_q && run_bit;

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   assign acc = psel && penable && pready;
   assign wr_lo = acc && pwrite && (paddr == `SBTC_ADDR_CNT_LO);
   assign wr_hi = acc && pwrite && (paddr == `SBTC_ADDR_CNT_HI);
   assign cnt_wr = wr_lo || wr_hi;
   assign trig = cmp_unit0_trigger || cmp_unit1_trigger;
   assign mapped = (paddr == `SBTC_ADDR_CTRL) || (paddr == `SBTC_ADDR_CNT_LO) ||
      (paddr == `SBTC_ADDR_CNT_HI) || (paddr == `SBTC_ADDR_STAT) ||
      (paddr == `SBTC_ADDR_MASK) || (paddr == `SBTC_ADDR_PDIR) ||
      (paddr == `SBTC_ADDR_PDAT);

   // ----------------------------------------------------------------
   // Count register
   // ----------------------------------------------------------------
   // Write to either half wins over trigger and increment in that cycle
   always_comb begin
      next_count = count;
      ovf = 1'b0;
      if (cnt_wr) begin
         if (wr_lo) begin
            next_count[7:0] = pwdata[7:0];
         end
         if (wr_hi) begin
            next_count[15:8] = pwdata[7:0];
         end
      end else if (trig) begin
         next_count = 16'h0000;
      end else if (inc) begin
         next_count = count + 16'h0001;
         ovf = (count == 16'hFFFF);
      end
   end

   // No reset branch: the count survives every reset
   always_ff @(posedge ref_clk) begin
      count <= next_count;
   end

   // ----------------------------------------------------------------
   // Control, interrupt and port registers
   // ----------------------------------------------------------------
   // Hardware set beats a write-one-to-clear in the same cycle
   always_comb begin
      next_ctrl = ctrl;
      next_overflow_irq_enable = overflow_irq_enable;
      next_port_dir = port_dir;
      next_port_out = port_out;
      next_overflow_flag = overflow_flag;
      if (acc && pwrite) begin
         case (paddr)
            `SBTC_ADDR_CTRL: next_ctrl = pwdata[`SBTC_CTRL_W-1:0];
            `SBTC_ADDR_MASK: next_overflow_irq_enable = pwdata[`SBTC_BIT_OVF];
            `SBTC_ADDR_PDIR: next_port_dir = pwdata[1:0];
            `SBTC_ADDR_PDAT: next_port_out = pwdata[1:0];
            `SBTC_ADDR_STAT: begin
               if (pwdata[`SBTC_BIT_OVF]) begin
                  next_overflow_flag = 1'b0;
               end
            end
            default: next_ctrl = ctrl;
         endcase
      end
      if (ovf) begin
         next_overflow_flag = 1'b1;
      end
   end

   // Pin drivers, interrupt line and oscillator power follow the next state
   always_comb begin
      next_irq = next_overflow_flag && next_overflow_irq_enable;
      next_in_oe_n = next_ctrl[`SBTC_BIT_OSC_EN] || next_port_dir[1];
      next_out_oe_n = next_ctrl[`SBTC_BIT_OSC_EN] || next_port_dir[0];
      next_inv_en = next_ctrl[`SBTC_BIT_OSC_EN];
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl <= `SBTC_RST_CTRL;
         overflow_flag <= 1'b0;
         overflow_irq_enable <= 1'b0;
         port_dir <= `SBTC_RST_PDIR;
         port_out <= `SBTC_RST_PDAT;
         irq <= 1'b0;
         osc_in_pin_oe_n <= 1'b1;
         osc_out_pin_oe_n <= 1'b1;
         osc_in_pin_o <= 1'b0;
         osc_out_pin_o <= 1'b0;
         osc_inverter_en <= 1'b0;
      end else begin
         ctrl <= next_ctrl;
         overflow_flag <= next_overflow_flag;
         overflow_irq_enable <= next_overflow_irq_enable;
         port_dir <= next_port_dir;
         port_out <= next_port_out;
         irq <= next_irq;
         osc_in_pin_oe_n <= next_in_oe_n;
         osc_out_pin_oe_n <= next_out_oe_n;
         osc_in_pin_o <= next_port_out[1];
         osc_out_pin_o <= next_port_out[0];
         osc_inverter_en <= next_inv_en;
      end
   end

   // ----------------------------------------------------------------
   // APB read path
   // ----------------------------------------------------------------
   // Read data captured in the setup cycle, so pready needs no wait
   always_comb begin
      next_prdata = 32'h0000_0000;
      next_pready = psel && !penable;
      next_pslverr = psel && !penable && !mapped;
      if (psel && !penable && !pwrite) begin
         case (paddr)
            `SBTC_ADDR_CTRL: next_prdata[`SBTC_CTRL_W-1:0] = ctrl;
            `SBTC_ADDR_CNT_LO: next_prdata[7:0] = count[7:0];
            `SBTC_ADDR_CNT_HI: next_prdata[7:0] = count[15:8];
            `SBTC_ADDR_STAT: next_prdata[`SBTC_BIT_OVF] = overflow_flag;
            `SBTC_ADDR_MASK: next_prdata[`SBTC_BIT_OVF] = overflow_irq_enable;
            `SBTC_ADDR_PDIR: next_prdata[1:0] = port_dir;
            `SBTC_ADDR_PDAT: begin
               if (!osc_enable) begin
                  next_prdata[1:0] = {osc_in_pin_i, osc_out_pin_i};
               end
            end
            default: next_prdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!arst_n);

   a_count_step: assert property (inc && !trig && !cnt_wr |=> count == $past(count) + 16'h0001)
      else $error("count did not step by one");
   a_wrap_flag: assert property (inc && !trig && !cnt_wr && count == 16'hFFFF |=>
      count == 16'h0000 && overflow_flag ##1 irq == overflow_irq_enable)
      else $error("wrap did not clear count and set flag");
   a_flag_sticky: assert property (overflow_flag && !(acc && pwrite &&
      paddr == `SBTC_ADDR_STAT && pwdata[0]) |=> overflow_flag)
      else $error("overflow flag dropped without clear");
   a_irq_gate: assert property (!overflow_irq_enable |-> !irq)
      else $error("irq high while disabled");
   a_timer_rate: assert property (!clock_source_select && ps_sel == sbtc_pkg::sbtc_ps_div1
      && inc |=> !inc [*3])
      else $error("timer mode counted faster than instruction rate");
   a_run_hold: assert property (!run_bit && !trig && !cnt_wr |=> $stable(count))
      else $error("count moved while stopped");
   a_trig_clear: assert property (trig && !cnt_wr |=> count == 16'h0000)
      else $error("trigger did not clear count");
   a_write_wins: assert property (wr_lo && trig |=> count[7:0] == $past(pwdata[7:0]))
      else $error("trigger beat software write");
   a_osc_pins: assert property (osc_enable |-> osc_in_pin_oe_n && osc_out_pin_oe_n)
      else $error("pin driven while oscillator enabled");
   a_osc_power: assert property (osc_inverter_en == osc_enable)
      else $error("inverter enable differs from control");

   c_wrap: cover property (ovf ##1 overflow_flag ##1 irq);
   c_counter_mode: cover property (clock_source_select && inc);
   c_write_trig: cover property (cnt_wr && trig);
endmodule : sbtc_top
